// ### verilog/jms_pkg.sv
// Constants, field layouts and types for the jog motion sequencer
package jms_pkg;
	// Parameter addresses on the parameter port
	localparam logic [15:0] ADDR_MODE = 16'h1b06;
	localparam logic [15:0] ADDR_REQ  = 16'h1b12;
	localparam logic [15:0] ADDR_SLOW = 16'h2908;
	localparam logic [15:0] ADDR_FAST = 16'h290a;
	localparam logic [15:0] ADDR_STEP = 16'h290e;
	localparam logic [15:0] ADDR_WAIT = 16'h2910;
	// Reset values
	localparam logic [15:0] RST_MODE = 16'h0000;
	localparam logic [15:0] RST_REQ  = 16'h0000;
	localparam logic [15:0] RST_SLOW = 16'h003c;
	localparam logic [15:0] RST_FAST = 16'h00b4;
	localparam logic [31:0] RST_STEP = 32'h00000014;
	localparam logic [15:0] RST_WAIT = 16'h01f4;
	// Mode code for jog (-1)
	localparam logic [15:0] MODE_JOG = 16'hffff;
	// Request field width and status bit positions
	localparam int REQ_W      = 3;
	localparam int ST_TARGET  = 10;
	localparam int ST_MODEDEP = 12;
	localparam int ST_ERR     = 13;
	localparam int ST_END     = 14;
	localparam int ST_REF     = 15;
	// Timing
	localparam int unsigned CLOCK_NS  = 10;
	localparam int unsigned MS_NS     = 1000000;
	localparam int unsigned MS_CYCLES = MS_NS / CLOCK_NS;
	// Request field: bit0 cw, bit1 ccw, bit2 fast
	typedef struct packed {
		logic fast;
		logic ccw;
		logic cw;
	} jms_req_s;
	typedef enum logic [1:0] {
		JMS_IDLE,
		JMS_INCH,
		JMS_CONT,
		JMS_STOP
	} jms_state_e;
endpackage

// ### verilog/jms_jog_sequencer.sv
// Jog sequencer: inching step, wait, continuous motion, status bits
//
// Contract
// - Simultaneous clockwise and counterclockwise requests command no movement.
// - A new request first commands one relative inching step in its direction.
// - Request still held after the wait time switches to continuous motion.
// - Zero step length starts continuous motion at once, wait time ignored.
// - Request field: bit0 clockwise, bit1 counterclockwise, bit2 fast select.
// - Slow 60 and fast 180 rpm defaults, clamped to maximum ramp speed.
// - Wait time in ms, default 500, used only for non-zero step.
// - Axis position at jog start is the origin of the inching move.
// - Status bit 10, target reached, always reads zero during jog.
// - Status bit 12 is reserved in jog and carries no meaning.
// - Status bits: 13 error, 14 completed at standstill, 15 reference valid.
// - Jog ends at standstill after release, halt or error.
// - Writing jog to the mode parameter starts the mode on that write.
// - Parameter writes take effect at once, also while running.
module jms_jog_sequencer #(
	parameter int unsigned MS_CYCLES = jms_pkg::MS_CYCLES
) (
	input  wire logic        clock_i,
	input  wire logic        rst_b_i,
	input  wire logic        par_wr_i,
	input  wire logic        par_rd_i,
	input  wire logic [15:0] par_addr_i,
	input  wire logic [31:0] par_wdata_i,
	output logic      [31:0] par_rdata_o,
	output logic             par_ack_o,
	output logic             par_err_o,
	input  wire logic        local_mode_i,
	input  wire logic        pin_cw_i,
	input  wire logic        pin_ccw_i,
	input  wire logic        pin_fast_i,
	input  wire logic [31:0] axis_pos_i,
	input  wire logic [15:0] max_ramp_speed_i,
	input  wire logic        standstill_i,
	input  wire logic        halt_i,
	input  wire logic        fault_i,
	input  wire logic        ref_valid_i,
	output logic             move_start_o,
	output logic      [31:0] move_target_o,
	output logic             cont_run_o,
	output logic             cont_ccw_o,
	output logic      [15:0] speed_ref_o,
	output logic             jog_active_o,
	output logic      [15:0] drive_status_word_o
);
	// Limit applied after speed select, so a lowered ramp limit bites mid-run
	function automatic logic [15:0] clamp_speed(input logic [15:0] v, input logic [15:0] lim);
		clamp_speed = (v > lim) ? lim : v;
	endfunction

	// Address and mode matches share one compare
	function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
		hit = (a == b);
	endfunction

	// Parameter registers
	logic [15:0] mode_select;
	logic [15:0] jog_request_bits;
	logic [15:0] slow_jog_speed;
	logic [15:0] fast_jog_speed;
	logic [31:0] inch_step_length;
	logic [15:0] continuous_wait_time;

	// Pin synchronisers, first stage feeds only the second
	logic [3:0] pin_meta;
	logic [3:0] pin_sync;

	// Sequencer state and the direction frozen at the start of a run
	jms_pkg::jms_state_e state;
	jms_pkg::jms_state_e next_state;
	logic                ccw_latched;
	logic                req_prev;
	logic                err_flag;
	logic                end_flag;
	logic [31:0]         prescale;
	logic [15:0]         ms_count;

	wire wr_mode = par_wr_i && hit(par_addr_i, jms_pkg::ADDR_MODE);
	wire wr_req  = par_wr_i && hit(par_addr_i, jms_pkg::ADDR_REQ);
	wire wr_slow = par_wr_i && hit(par_addr_i, jms_pkg::ADDR_SLOW);
	wire wr_fast = par_wr_i && hit(par_addr_i, jms_pkg::ADDR_FAST);
	wire wr_step = par_wr_i && hit(par_addr_i, jms_pkg::ADDR_STEP);
	wire wr_wait = par_wr_i && hit(par_addr_i, jms_pkg::ADDR_WAIT);

	wire mapped = hit(par_addr_i, jms_pkg::ADDR_MODE) || hit(par_addr_i, jms_pkg::ADDR_REQ)
		|| hit(par_addr_i, jms_pkg::ADDR_SLOW) || hit(par_addr_i, jms_pkg::ADDR_FAST)
		|| hit(par_addr_i, jms_pkg::ADDR_STEP) || hit(par_addr_i, jms_pkg::ADDR_WAIT);

	// Unmapped reads return zero and raise the error flag with the acknowledge
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h00000000;
		case (par_addr_i)
			jms_pkg::ADDR_MODE: rd_mux = {16'h0000, mode_select};
			jms_pkg::ADDR_REQ:  rd_mux = {16'h0000, jog_request_bits};
			jms_pkg::ADDR_SLOW: rd_mux = {16'h0000, slow_jog_speed};
			jms_pkg::ADDR_FAST: rd_mux = {16'h0000, fast_jog_speed};
			jms_pkg::ADDR_STEP: rd_mux = inch_step_length;
			jms_pkg::ADDR_WAIT: rd_mux = {16'h0000, continuous_wait_time};
			default:            rd_mux = 32'h00000000;
		endcase
	end

	// Request source: synchronised pins in local mode, else the parameter
	jms_pkg::jms_req_s req;
	assign req = pin_sync[3] ? jms_pkg::jms_req_s'(pin_sync[2:0])
		: jms_pkg::jms_req_s'(jog_request_bits[jms_pkg::REQ_W-1:0]);

	wire mode_jog  = pin_sync[3] || hit(mode_select, jms_pkg::MODE_JOG);
	wire req_valid = mode_jog && (req.cw ^ req.ccw);
	wire dir_held  = req_valid && (req.ccw == ccw_latched);
	// Any loss of the latched direction also ends the run
	wire abort     = halt_i || fault_i || !dir_held;
	wire mode_kick = wr_mode && hit(par_wdata_i[15:0], jms_pkg::MODE_JOG);
	// Fresh request edge or a jog mode write needed, so a request merely held through a halt cannot restart
	wire start     = req_valid && !halt_i && !fault_i && (!req_prev || mode_kick);
	wire step_zero = (inch_step_length == 32'h00000000);
	// Live compare so a wait-time write acts on a running inch
	wire wait_done = (ms_count >= continuous_wait_time);
	wire ms_tick   = (prescale == MS_CYCLES - 32'd1);

	always_comb begin
		next_state = state;
		case (state)
			jms_pkg::JMS_IDLE: begin
				if (start) begin
					next_state = step_zero ? jms_pkg::JMS_CONT : jms_pkg::JMS_INCH;
				end
			end
			jms_pkg::JMS_INCH: begin
				if (abort) begin
					next_state = jms_pkg::JMS_STOP;
				end else if (wait_done) begin
					next_state = jms_pkg::JMS_CONT;
				end
			end
			jms_pkg::JMS_CONT: begin
				if (abort) begin
					next_state = jms_pkg::JMS_STOP;
				end
			end
			jms_pkg::JMS_STOP: begin
				if (standstill_i) begin
					next_state = jms_pkg::JMS_IDLE;
				end
			end
			default: next_state = jms_pkg::JMS_IDLE;
		endcase
	end

	// Strobes derived from the next state, so outputs line up with the state
	wire       begin_inch = (state == jms_pkg::JMS_IDLE) && (next_state == jms_pkg::JMS_INCH);
	wire       running    = (next_state == jms_pkg::JMS_INCH) || (next_state == jms_pkg::JMS_CONT);
	wire       finishing  = (state == jms_pkg::JMS_STOP) && standstill_i;
	wire [31:0] next_target = req.ccw ? axis_pos_i - inch_step_length
		: axis_pos_i + inch_step_length;
	// Fast bit read live, so a change retargets the ramp mid-run
	wire [15:0] next_speed = running ? clamp_speed(req.fast ? fast_jog_speed : slow_jog_speed,
		max_ramp_speed_i) : 16'h0000;

	// Bits 10 and 12 stay low in jog; the error bit also shows a live fault
	logic [15:0] next_status;
	always_comb begin
		next_status = 16'h0000;
		next_status[jms_pkg::ST_TARGET]  = 1'b0;
		next_status[jms_pkg::ST_MODEDEP] = 1'b0;
		next_status[jms_pkg::ST_ERR]     = err_flag || fault_i;
		next_status[jms_pkg::ST_END]     = end_flag || finishing;
		next_status[jms_pkg::ST_REF]     = ref_valid_i;
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pin_meta <= 4'h0;
			pin_sync <= 4'h0;
		end else begin
			pin_meta <= {local_mode_i, pin_fast_i, pin_ccw_i, pin_cw_i};
			pin_sync <= pin_meta;
		end
	end

	// Mode and request writes; a jog mode write also starts the mode
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mode_select      <= jms_pkg::RST_MODE;
			jog_request_bits <= jms_pkg::RST_REQ;
		end else begin
			if (wr_mode) mode_select <= par_wdata_i[15:0];
			if (wr_req)  jog_request_bits <= par_wdata_i[15:0];
		end
	end

	// Tuning writes land at once, whatever the sequencer state
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			slow_jog_speed       <= jms_pkg::RST_SLOW;
			fast_jog_speed       <= jms_pkg::RST_FAST;
			inch_step_length     <= jms_pkg::RST_STEP;
			continuous_wait_time <= jms_pkg::RST_WAIT;
		end else begin
			if (wr_slow) slow_jog_speed <= par_wdata_i[15:0];
			if (wr_fast) fast_jog_speed <= par_wdata_i[15:0];
			if (wr_step) inch_step_length <= par_wdata_i;
			if (wr_wait) continuous_wait_time <= par_wdata_i[15:0];
		end
	end

	// Never busy: every strobe is answered on the next cycle
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			par_rdata_o <= 32'h00000000;
			par_ack_o   <= 1'b0;
			par_err_o   <= 1'b0;
		end else begin
			par_rdata_o <= par_rd_i ? rd_mux : par_rdata_o;
			par_ack_o   <= par_rd_i || par_wr_i;
			par_err_o   <= (par_rd_i || par_wr_i) && !mapped;
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state       <= jms_pkg::JMS_IDLE;
			ccw_latched <= 1'b0;
			req_prev    <= 1'b0;
		end else begin
			state       <= next_state;
			ccw_latched <= start && (state == jms_pkg::JMS_IDLE) ? req.ccw : ccw_latched;
			req_prev    <= req_valid;
		end
	end

	// Millisecond base restarts with each inching step
	// Count saturates so a long wait cannot wrap back under the limit
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prescale <= 32'h00000000;
			ms_count <= 16'h0000;
		end else if (begin_inch) begin
			prescale <= 32'h00000000;
			ms_count <= 16'h0000;
		end else begin
			prescale <= ms_tick ? 32'h00000000 : prescale + 32'd1;
			ms_count <= (ms_tick && ms_count != 16'hffff) ? ms_count + 16'd1 : ms_count;
		end
	end

	// Error and end flags; a set in the clearing cycle wins
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			err_flag <= 1'b0;
			end_flag <= 1'b0;
		end else begin
			err_flag <= fault_i || (err_flag && !mode_kick);
			end_flag <= finishing || (end_flag && !(start && state == jms_pkg::JMS_IDLE));
		end
	end

	// Target latched only on a new inch, so it stays readable afterwards
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			move_start_o  <= 1'b0;
			move_target_o <= 32'h00000000;
		end else begin
			move_start_o  <= begin_inch;
			move_target_o <= begin_inch ? next_target : move_target_o;
		end
	end

	// Direction follows the request while idle, then stays frozen for the run
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cont_run_o <= 1'b0;
			cont_ccw_o <= 1'b0;
		end else begin
			cont_run_o <= (next_state == jms_pkg::JMS_CONT);
			cont_ccw_o <= (state == jms_pkg::JMS_IDLE) ? req.ccw : ccw_latched;
		end
	end

	// Speed drops to zero in STOP; the ramp outside brings the motor down
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			speed_ref_o  <= 16'h0000;
			jog_active_o <= 1'b0;
		end else begin
			speed_ref_o  <= next_speed;
			jog_active_o <= (next_state != jms_pkg::JMS_IDLE);
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			drive_status_word_o <= 16'h0000;
		end else begin
			drive_status_word_o <= next_status;
		end
	end
endmodule // jms_jog_sequencer

// ### dv/jms_props.sv
// Port checker for the jog sequencer
module jms_props #(
	parameter int unsigned MS_CYCLES = 4
) (
	input wire logic        clock_i,
	input wire logic        rst_b_i,
	input wire logic        par_wr_i,
	input wire logic [15:0] par_addr_i,
	input wire logic [31:0] par_wdata_i,
	input wire logic        local_mode_i,
	input wire logic [31:0] axis_pos_i,
	input wire logic [15:0] max_ramp_speed_i,
	input wire logic        standstill_i,
	input wire logic        fault_i,
	input wire logic        ref_valid_i,
	input wire logic        move_start_o,
	input wire logic [31:0] move_target_o,
	input wire logic        cont_run_o,
	input wire logic        cont_ccw_o,
	input wire logic [15:0] speed_ref_o,
	input wire logic        jog_active_o,
	input wire logic [15:0] drive_status_word_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] step_q;
	// Shadow of the step length, needed to predict inching targets
	always_ff @(posedge clock_i or negedge rst_b_i)
		if (!rst_b_i) step_q <= jms_pkg::RST_STEP;
		else if (par_wr_i && par_addr_i == jms_pkg::ADDR_STEP) step_q <= par_wdata_i;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	property p_flags; !drive_status_word_o[jms_pkg::ST_TARGET] && !drive_status_word_o[jms_pkg::ST_MODEDEP]; endproperty
	a_flags: assert property (p_flags) else $error("status flag 10 or 12 set");
	property p_ref; $past(rst_b_i, 2) |-> drive_status_word_o[jms_pkg::ST_REF] == $past(ref_valid_i); endproperty
	a_ref: assert property (p_ref) else $error("reference flag wrong");
	property p_err; fault_i |=> drive_status_word_o[jms_pkg::ST_ERR]; endproperty
	a_err: assert property (p_err) else $error("error flag missing");
	property p_start; move_start_o |-> jog_active_o && !$past(jog_active_o) && $past(step_q) != 32'h0; endproperty
	a_start: assert property (p_start) else $error("inching start wrong");
	property p_inch;
		move_start_o |-> move_target_o == (cont_ccw_o ? $past(axis_pos_i) - $past(step_q)
			: $past(axis_pos_i) + $past(step_q));
	endproperty
	a_inch: assert property (p_inch) else $error("inching target wrong");
	property p_both;
		!local_mode_i && par_wr_i && par_addr_i == jms_pkg::ADDR_REQ && par_wdata_i[1:0] == 2'h3
			|-> ##2 !move_start_o && !cont_run_o;
	endproperty
	a_both: assert property (p_both) else $error("motion with both directions");
	property p_clamp; $past(rst_b_i) |-> speed_ref_o <= $past(max_ramp_speed_i); endproperty
	a_clamp: assert property (p_clamp) else $error("speed above ramp limit");
	property p_end;
		jog_active_o && !cont_run_o && speed_ref_o == 16'h0 && standstill_i && !move_start_o
			|=> !jog_active_o && drive_status_word_o[jms_pkg::ST_END];
	endproperty
	a_end: assert property (p_end) else $error("jog did not finish");
	c_inch: cover property (move_start_o);
	c_cont: cover property (cont_run_o);
	c_err: cover property (drive_status_word_o[jms_pkg::ST_ERR]);
	c_end: cover property (drive_status_word_o[jms_pkg::ST_END]);
endmodule // jms_props

// ### dv/jms_motor.sv
// Motor model: coasts a few cycles after the speed reference drops
module jms_motor (
	input  wire logic        clock_i,
	input  wire logic        rst_b_i,
	input  wire logic [15:0] speed_i,
	output logic             standstill_o,
	output logic      [31:0] pos_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] coast;
	assign standstill_o = coast == 2'h0 && speed_i == 16'h0;
	always_ff @(posedge clock_i or negedge rst_b_i)
		if (!rst_b_i) begin
			coast <= 2'h0;
			pos_o <= 32'h00000100;
		end else begin
			coast <= speed_i != 16'h0 ? 2'h3 : coast - 2'(coast != 2'h0);
			pos_o <= pos_o + 32'(!standstill_o);
		end
endmodule // jms_motor

// ### dv/test_jog_motion_sequencer.sv
// Self-checking bench for the jog sequencer
module test_jog_motion_sequencer;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock_i, rst_b_i, par_wr_i, par_rd_i, fault_i, ref_valid_i, standstill_i, halt_i;
	logic        local_mode_i, pin_cw_i, pin_ccw_i, pin_fast_i;
	logic        par_ack_o, par_err_o, move_start_o, cont_run_o, cont_ccw_o, jog_active_o;
	logic [15:0] par_addr_i, max_ramp_speed_i, speed_ref_o, drive_status_word_o;
	logic [31:0] par_wdata_i, par_rdata_o, axis_pos_i, move_target_o;
	logic [33:0] b;
	logic [33:0] bq[$];
	logic [31:0] mq[$];
	int          mismatches, checks, cyc;
	logic [15:0] ad[6] = '{jms_pkg::ADDR_MODE, jms_pkg::ADDR_REQ, jms_pkg::ADDR_SLOW,
		jms_pkg::ADDR_FAST, jms_pkg::ADDR_STEP, jms_pkg::ADDR_WAIT};
	logic [31:0] dv[6] = '{32'h0, 32'h0, 32'h3c, 32'hb4, 32'h14, 32'h1f4};
	jms_jog_sequencer #(.MS_CYCLES(4)) dut_u (.clock_i, .rst_b_i, .par_wr_i, .par_rd_i, .par_addr_i,
		.par_wdata_i, .par_rdata_o, .par_ack_o, .par_err_o, .local_mode_i, .pin_cw_i,
		.pin_ccw_i, .pin_fast_i, .axis_pos_i, .max_ramp_speed_i, .standstill_i, .halt_i,
		.fault_i, .ref_valid_i, .move_start_o, .move_target_o, .cont_run_o, .cont_ccw_o, .speed_ref_o,
		.jog_active_o, .drive_status_word_o);
	jms_motor mot_u (.clock_i, .rst_b_i, .speed_i(speed_ref_o), .standstill_o(standstill_i), .pos_o(axis_pos_i));
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task acc(input logic w, input logic [15:0] a, input logic [31:0] d, input logic e, input logic [31:0] x);
		par_wr_i = w;
		par_rd_i = !w;
		par_addr_i = a;
		par_wdata_i = d;
		bq.push_back({!w, e, x});
		@(negedge clock_i);
		par_wr_i = 1'b0;
		par_rd_i = 1'b0;
		@(negedge clock_i);
	endtask
	task jog(input logic [2:0] q, input logic [31:0] s, input logic [15:0] v, input logic [15:0] v2);
		ref_valid_i = 1'($urandom);
		acc(1, jms_pkg::ADDR_STEP, s, 0, 0);
		if (s != 0) mq.push_back(q[1] ? axis_pos_i - s : axis_pos_i + s);
		acc(1, jms_pkg::ADDR_REQ, {29'h0, q}, 0, 0);
		if (s != 0) chk("inch", 0, 32'(cont_run_o));
		repeat (s != 0 ? 40 : 1) if (cont_run_o !== 1'b1) @(negedge clock_i);
		chk("cont", 1, 32'(cont_run_o));
		chk("speed", 32'(v), 32'(speed_ref_o));
		chk("dir", 32'(q[1]), 32'(cont_ccw_o));
		acc(1, jms_pkg::ADDR_REQ, {29'h0, ~q[2], q[1:0]}, 0, 0);
		@(negedge clock_i);
		chk("retarget", 32'(v2), 32'(speed_ref_o));
		acc(1, jms_pkg::ADDR_REQ, 32'h0, 0, 0);
		repeat (40) if (jog_active_o !== 1'b0) @(negedge clock_i);
		chk("end", 1, 32'(drive_status_word_o[jms_pkg::ST_END]));
	endtask
	always @(negedge clock_i) begin
		if (par_ack_o === 1'b1) begin
			if (bq.size() > 0) begin
				b = bq.pop_front();
				chk("err", 32'(b[32]), 32'(par_err_o));
				if (b[33]) chk("rdata", b[31:0], par_rdata_o);
			end else begin
				chk("ack", 0, 1);
			end
		end
		if (move_start_o === 1'b1) begin
			if (mq.size() > 0) chk("target", mq.pop_front(), move_target_o);
			else chk("start", 0, 1);
		end
	end
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			conclude();
		end
	end
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	initial begin
		{rst_b_i, par_wr_i, par_rd_i, fault_i, ref_valid_i, halt_i} = 6'h00;
		{local_mode_i, pin_cw_i, pin_ccw_i, pin_fast_i} = 4'h0;
		par_addr_i = 16'h0;
		par_wdata_i = 32'h0;
		max_ramp_speed_i = 16'h03e8;
		void'($urandom(50377));
		repeat (20) @(negedge clock_i);
		rst_b_i = 1'b1;
		for (int i = 0; i < 6; i++) acc(0, ad[i], 0, 0, dv[i]);
		acc(0, 16'h1b13, 0, 1, 0);
		acc(1, 16'h1b13, 32'h5, 1, 0);
		acc(1, jms_pkg::ADDR_WAIT, 32'h2, 0, 0);
		acc(0, jms_pkg::ADDR_WAIT, 0, 0, 32'h2);
		acc(1, jms_pkg::ADDR_MODE, 32'(jms_pkg::MODE_JOG), 0, 0);
		jog(3'h1, $urandom_range(200, 1), 16'h3c, 16'hb4);
		max_ramp_speed_i = 16'h0064;
		jog(3'h6, $urandom_range(200, 1), 16'h64, 16'h3c);
		max_ramp_speed_i = 16'h03e8;
		jog(3'h1, 32'h0, 16'h3c, 16'hb4);
		acc(1, jms_pkg::ADDR_REQ, 32'h1, 0, 0);
		chk("run", 1, 32'(cont_run_o));
		halt_i = 1'b1;
		repeat (40) if (jog_active_o !== 1'b0) @(negedge clock_i);
		chk("halt", 1, 32'(drive_status_word_o[jms_pkg::ST_END]));
		halt_i = 1'b0;
		repeat (5) @(negedge clock_i);
		chk("hold", 0, 32'(jog_active_o));
		acc(1, jms_pkg::ADDR_REQ, 32'h0, 0, 0);
		{local_mode_i, pin_ccw_i} = 2'h3;
		repeat (6) @(negedge clock_i);
		chk("pinrun", 1, 32'(cont_run_o));
		chk("pindir", 1, 32'(cont_ccw_o));
		pin_fast_i = 1'b1;
		repeat (4) @(negedge clock_i);
		chk("pinfast", 32'hb4, 32'(speed_ref_o));
		pin_cw_i = 1'b1;
		repeat (40) if (jog_active_o !== 1'b0) @(negedge clock_i);
		chk("pinboth", 1, 32'(drive_status_word_o[jms_pkg::ST_END]));
		{local_mode_i, pin_cw_i, pin_ccw_i, pin_fast_i} = 4'h0;
		acc(1, jms_pkg::ADDR_REQ, 32'h3, 0, 0);
		repeat (10) @(negedge clock_i);
		chk("both", 0, 32'(jog_active_o));
		acc(1, jms_pkg::ADDR_REQ, 32'h0, 0, 0);
		fault_i = 1'b1;
		@(negedge clock_i);
		fault_i = 1'b0;
		repeat (2) @(negedge clock_i);
		chk("errflag", 1, 32'(drive_status_word_o[jms_pkg::ST_ERR]));
		acc(1, jms_pkg::ADDR_MODE, 32'(jms_pkg::MODE_JOG), 0, 0);
		@(negedge clock_i);
		chk("errclr", 0, 32'(drive_status_word_o[jms_pkg::ST_ERR]));
		chk("pending", 0, 32'(mq.size() + bq.size()));
		conclude();
	end
endmodule // test_jog_motion_sequencer
bind jms_jog_sequencer jms_props #(.MS_CYCLES(MS_CYCLES)) u_props (.clock_i, .rst_b_i, .par_wr_i, .par_addr_i,
	.par_wdata_i, .local_mode_i, .axis_pos_i, .max_ramp_speed_i, .standstill_i, .fault_i, .ref_valid_i,
	.move_start_o, .move_target_o, .cont_run_o, .cont_ccw_o, .speed_ref_o, .jog_active_o, .drive_status_word_o);
